// file: src/lfsd_pkg.sv
// Shared constants and types for the link fault / signal detect block.
// Assumes one 25 MHz clock that also serves as the reference clock.
`default_nettype none
package lfsd_pkg;
  localparam int NCH = 2;
  // Reference clock rate; one reference period per sys_clk cycle
  localparam int CLK_MHZ = 25;
  // Range control sampling interval, in reference periods
  localparam int RANGE_PERIODS = 16000;
  // Reference periods the VCO is held on the reference while forced
  localparam int FORCE_PERIODS = 8;
  localparam logic [2:0] FORCE_LAST = 3'(FORCE_PERIODS - 1);
  // Character framing and transition density limits in bit periods; recovery count in characters
  localparam logic [3:0] CHAR_LAST = 4'h9;
  localparam logic [6:0] NOTRANS_LIMIT = 7'h3c;
  localparam logic [6:0] GAP_MAX = 7'h7f;
  localparam logic [1:0] RECOVER_LAST = 2'h2;
  // Amplitude threshold select codes and quantised amplitude codes
  localparam logic [1:0] THR_LOW = 2'h0;
  localparam logic [1:0] THR_MID = 2'h1;
  localparam logic [1:0] THR_HIGH = 2'h2;
  // Register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ENABLE = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  // Control register fields
  localparam int CTRL_LOOP = 0;
  localparam int CTRL_THR = 1;
  localparam int CTRL_HALF = 3;
  localparam int CTRL_INSEL = 4;
  // Enable register fields
  localparam int ENA_BITS = 0;
  localparam int ENA_STROBE = 4;
  // Status register fields
  localparam int STAT_LFI_N = 0;
  localparam int STAT_FORCE = 2;
  localparam int STAT_DENS = 4;
  localparam int STAT_EN = 6;
  // Range control states
  typedef enum logic [1:0] {
    LFSD_RC_TRACK,
    LFSD_RC_FORCE,
    LFSD_RC_RELOCK
  } lfsd_rc_t;
endpackage
`default_nettype wire

// file: src/lfsd_dens.sv
// Per-channel transition density monitor with port and loopback selection.
// Assumes serial bit samples arrive asynchronously, one bit per clock.
`default_nettype none
module lfsd_dens (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Serial bit samples
  input wire logic line1_bit,
  input wire logic line2_bit,
  input wire logic loop_bit,
  // Control from same clock domain
  input wire logic port_sel,
  input wire logic loop_en,
  input wire logic hold,
  // Status
  output logic dens_fault
);
  import lfsd_pkg::*;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic prev;
    logic [6:0] gap;
    logic [3:0] phase;
    logic seen;
    logic [1:0] good;
    logic fault;
  } lfsd_dens_st_t;

  lfsd_dens_st_t r, n;
  logic cur_bit, trans, had;

  always_comb begin
    n = r;
    n.s1 = {loop_bit, line2_bit, line1_bit};
    n.s2 = r.s1;
    // Loopback replaces both line ports
    cur_bit = loop_en ? r.s2[2] : (port_sel ? r.s2[1] : r.s2[0]);
    trans = cur_bit ^ r.prev;
    had = r.seen | trans;
    n.prev = cur_bit;
    // Bits since the last transition, saturating
    if (trans) begin
      n.gap = 7'h00;
    end else if (r.gap != GAP_MAX) begin
      n.gap = r.gap + 7'h01;
    end
    n.phase = (r.phase == CHAR_LAST) ? 4'h0 : r.phase + 4'h1;
    n.seen = (r.phase == CHAR_LAST) ? 1'b0 : had;
    // Three adjacent characters with a transition clear the fault
    if (r.phase == CHAR_LAST) begin
      if (r.fault && had) begin
        if (r.good == RECOVER_LAST) begin
          n.fault = 1'b0;
          n.good = 2'h0;
        end else begin
          n.good = r.good + 2'h1;
        end
      end else begin
        n.good = 2'h0;
      end
    end
    // Set wins over a clear in the same cycle
    if (!trans && r.gap >= NOTRANS_LIMIT) begin
      n.fault = 1'b1;
      n.good = 2'h0;
    end
    // Disabled channel: monitor idles, needs fresh recovery on re-enable
    if (hold) begin
      n.gap = 7'h00;
      n.phase = 4'h0;
      n.seen = 1'b0;
      n.good = 2'h0;
      n.fault = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '0;
      r.fault <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign dens_fault = r.fault;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_GAP_SETS_FAULT: assert property (
    (!hold && !trans && r.gap >= NOTRANS_LIMIT) |=> r.fault)
    else $error("No-transition span above limit did not raise fault");
  AST_CLEAR_NEEDS_THREE: assert property (
    $fell(r.fault) |-> ($past(r.good) == RECOVER_LAST && $past(r.phase) == CHAR_LAST))
    else $error("Fault cleared without three good characters");
endmodule
`default_nettype wire

// file: src/lfsd_top.sv
// Link fault / signal detect block for a two-channel serial receiver.
// Assumes an Avalon-MM master on sys_clk; analog and serial inputs are async pins.
//
// Contract
// - One amplitude threshold select applies to every channel's analog monitor.
// - Analog detect watches only the line receiver chosen by input port select.
// - In loopback, fault reflects only range status and own transmit density.
// - Loopback disables analog signal detect on all channels.
// - No transitions for more than sixty bit periods asserts the fault.
// - Fault stays until three adjacent characters each show a transition.
// - Range control samples VCO deviation, forces it, then releases to relock.
// - Sampling and relock interval is sixteen thousand reference periods.
// - While the VCO is forced, the link fault indicator is driven low.
// - During relock the indicator follows other conditions; lock within one interval.
// - Enable latch passes inputs while strobe high, holds on strobe low.
// - High enable bit enables a channel; low bit powers it down.
// - A disabled receive channel shows an asserted fault.
// - Reference clock may be character rate or half-character rate.
// - Out of range, recovery tracks the reference, then returns to data.
// - Valid signal needs amplitude, density, range and enable all good.
// - Indicator changes synchronously to the channel's receive clock.
// - Enable bit 2 controls channel B, bit 0 channel A; others ignored.
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`default_nettype none
module lfsd_top #(
  parameter int RANGE_PERIODS_P = lfsd_pkg::RANGE_PERIODS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Analog amplitude codes per channel and port: 0 none, 1..3 above each level
  input wire logic [1:0] ch0_port1_amp,
  input wire logic [1:0] ch0_port2_amp,
  input wire logic [1:0] ch1_port1_amp,
  input wire logic [1:0] ch1_port2_amp,
  // Recovered serial bits and looped-back transmit bits
  input wire logic [1:0] line1_bit,
  input wire logic [1:0] line2_bit,
  input wire logic [1:0] loop_bit,
  // VCO deviation comparator, high beyond the ppm window
  input wire logic [1:0] vco_out_of_range,
  // Outputs to the receive channels
  output logic [1:0] link_fault_indicator_n,
  output logic [1:0] vco_force_ref,
  output logic vco_mult_20,
  output logic [1:0] rx_chan_enable,
  output logic [1:0] input_port_select,
  output logic amp_monitor_enable,
  output logic [1:0] amplitude_threshold_select
);
  import lfsd_pkg::*;

  localparam logic [13:0] RC_LAST = 14'(RANGE_PERIODS_P - 1);

  typedef struct packed {
    logic [1:0][1:0][1:0] amp_s1;
    logic [1:0][1:0][1:0] amp_s2;
    logic [1:0] oor_s1;
    logic [1:0] oor_s2;
    logic loop;
    logic amp_en;
    logic [1:0] thr;
    logic half;
    logic [1:0] insel;
    logic [3:0] en_in;
    logic strobe;
    logic [3:0] en_lat;
    logic [13:0] tick_cnt;
    logic tick;
    lfsd_rc_t [1:0] rc;
    logic [1:0][2:0] force_cnt;
    logic [1:0] lfi_n;
    logic [1:0] force_ref;
    logic wr;
    logic [31:0] rdata;
  } lfsd_top_st_t;

  lfsd_top_st_t r, n;
  logic [1:0] dens_fault;
  logic [1:0] amp_ok;
  logic [1:0] chan_en;
  logic [1:0] valid;
  logic bus_req;
  logic bus_ack;

  // Channel A sits on enable bit 0, channel B on bit 2
  assign chan_en = {r.en_lat[2], r.en_lat[0]};
  assign bus_req = avs_read | avs_write;
  // Request taken only while waitrequest stands high
  assign bus_ack = bus_req & r.wr;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      lfsd_dens u_dens (
        .sys_clk(sys_clk),
        .rst(rst),
        .line1_bit(line1_bit[g]),
        .line2_bit(line2_bit[g]),
        .loop_bit(loop_bit[g]),
        .port_sel(r.insel[g]),
        .loop_en(r.loop),
        .hold(~chan_en[g]),
        .dens_fault(dens_fault[g])
      );
      // Shared threshold, selected port only
      assign amp_ok[g] = r.amp_s2[g][r.insel[g]] > r.thr;
      // All conditions at once; loopback drops amplitude
      assign valid[g] = chan_en[g] & (r.loop | amp_ok[g]) & ~dens_fault[g]
        & ~r.oor_s2[g] & (r.rc[g] != LFSD_RC_FORCE);
    end
  endgenerate

  always_comb begin
    n = r;
    n.amp_s1 = {ch1_port2_amp, ch1_port1_amp, ch0_port2_amp, ch0_port1_amp};
    n.amp_s2 = r.amp_s1;
    n.oor_s1 = vco_out_of_range;
    n.oor_s2 = r.oor_s1;

    // Sampling interval counted in reference periods
    if (r.tick_cnt == RC_LAST) begin
      n.tick_cnt = 14'h0000;
      n.tick = 1'b1;
    end else begin
      n.tick_cnt = r.tick_cnt + 14'h0001;
      n.tick = 1'b0;
    end

    // One wait cycle, then a single-cycle acknowledge
    n.wr = ~bus_ack;
    if (avs_read && r.wr) begin
      case (avs_address)
        REG_CTRL: begin
          n.rdata = 32'h0;
          n.rdata[CTRL_LOOP] = r.loop;
          n.rdata[CTRL_THR +: 2] = r.thr;
          n.rdata[CTRL_HALF] = r.half;
          n.rdata[CTRL_INSEL +: 2] = r.insel;
        end
        REG_ENABLE: begin
          n.rdata = 32'h0;
          n.rdata[ENA_BITS +: 4] = r.en_in;
          n.rdata[ENA_STROBE] = r.strobe;
        end
        REG_STATUS: begin
          n.rdata = 32'h0;
          n.rdata[STAT_LFI_N +: 2] = r.lfi_n;
          n.rdata[STAT_FORCE +: 2] = r.force_ref;
          n.rdata[STAT_DENS +: 2] = dens_fault;
          n.rdata[STAT_EN +: 2] = chan_en;
        end
        default: begin
          n.rdata = 32'h0;
        end
      endcase
    end
    if (avs_write && !r.wr && avs_byteenable[0]) begin
      case (avs_address)
        REG_CTRL: begin
          n.loop = avs_writedata[CTRL_LOOP];
          n.thr = avs_writedata[CTRL_THR +: 2];
          n.half = avs_writedata[CTRL_HALF];
          n.insel = avs_writedata[CTRL_INSEL +: 2];
        end
        REG_ENABLE: begin
          n.en_in = avs_writedata[ENA_BITS +: 4];
          n.strobe = avs_writedata[ENA_STROBE];
        end
        default: begin
          n.rdata = r.rdata;
        end
      endcase
    end
    n.amp_en = ~r.loop;

    // Transparent while strobe high, holds otherwise
    if (r.strobe) begin
      n.en_lat = r.en_in;
    end

    for (int c = 0; c < NCH; c++) begin
      // Sample, force to reference, release to relock
      case (r.rc[c])
        LFSD_RC_TRACK: begin
          if (r.tick && r.oor_s2[c]) begin
            n.rc[c] = LFSD_RC_FORCE;
            n.force_cnt[c] = 3'h0;
          end
        end
        LFSD_RC_FORCE: begin
          if (r.force_cnt[c] == FORCE_LAST) begin
            n.rc[c] = LFSD_RC_RELOCK;
          end else begin
            n.force_cnt[c] = r.force_cnt[c] + 3'h1;
          end
        end
        LFSD_RC_RELOCK: begin
          // Indicator free to follow other monitors here
          if (r.tick) begin
            n.rc[c] = r.oor_s2[c] ? LFSD_RC_FORCE : LFSD_RC_TRACK;
            n.force_cnt[c] = 3'h0;
          end
        end
        default: begin
          n.rc[c] = LFSD_RC_TRACK;
        end
      endcase
      if (!chan_en[c]) begin
        n.rc[c] = LFSD_RC_TRACK;
      end
      n.force_ref[c] = (r.rc[c] == LFSD_RC_FORCE);
      // Forced or disabled channel reads low
      // Single clock here stands in for the channel's receive clock
      n.lfi_n[c] = valid[c];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '0;
      r.wr <= 1'b1;
      r.amp_en <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign avs_readdata = r.rdata;
  assign avs_waitrequest = r.wr;
  assign link_fault_indicator_n = r.lfi_n;
  assign vco_force_ref = r.force_ref;
  // Multiplier 20 for half-rate reference, else 10
  assign vco_mult_20 = r.half;
  assign rx_chan_enable = chan_en;
  assign input_port_select = r.insel;
  assign amp_monitor_enable = r.amp_en;
  assign amplitude_threshold_select = r.thr;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_force_entry(int c);
    (r.rc[c] == LFSD_RC_TRACK || r.rc[c] == LFSD_RC_RELOCK) && r.tick && r.oor_s2[c]
      && chan_en[c];
  endsequence
  sequence s_force_hold(int c);
    (r.rc[c] == LFSD_RC_FORCE && chan_en[c]) [*8];
  endsequence

  AST_FORCE_SEQUENCE: assert property (
    s_force_entry(0) |=> s_force_hold(0) ##0 chan_en[0] |=> r.rc[0] == LFSD_RC_RELOCK)
    else $error("Forced phase did not last eight periods before relock");
  AST_FORCE_LFI_LOW: assert property (
    r.rc[0] == LFSD_RC_FORCE |=> !link_fault_indicator_n[0] && vco_force_ref[0])
    else $error("Indicator not low while VCO forced");
  AST_TICK_SPACING: assert property (
    r.tick |-> r.tick_cnt == 14'h0000 || RANGE_PERIODS_P == 1)
    else $error("Sampling tick off interval boundary");
  AST_DISABLED_FAULT: assert property (
    !chan_en[0] |=> !link_fault_indicator_n[0])
    else $error("Disabled channel shows valid signal");
  AST_LATCH_HOLD: assert property (
    !r.strobe |=> r.en_lat == $past(r.en_lat))
    else $error("Enable latch changed while closed");
  AST_LATCH_PASS: assert property (
    r.strobe ##1 r.strobe |-> r.en_lat == $past(r.en_in))
    else $error("Enable latch not transparent");
  AST_DENS_FAULT: assert property (
    dens_fault[1] |=> !link_fault_indicator_n[1])
    else $error("Density fault did not reach indicator");
  AST_AMP_FAULT: assert property (
    (!r.loop && !amp_ok[0]) |=> !link_fault_indicator_n[0])
    else $error("Low amplitude did not reach indicator");
  AST_LOOP_NO_AMP: assert property (
    (r.loop && chan_en[0] && !dens_fault[0] && !r.oor_s2[0]
      && r.rc[0] != LFSD_RC_FORCE) |=> link_fault_indicator_n[0] && !amp_monitor_enable)
    else $error("Loopback still gated by amplitude");
  AST_ALL_GOOD: assert property (
    $rose(link_fault_indicator_n[1]) |-> $past(chan_en[1] && amp_ok[1] | r.loop))
    else $error("Valid signal without enable and amplitude");
  // Bus transfer steps: request taken, then one low cycle of waitrequest
  sequence s_bus_take;
    bus_req && avs_waitrequest;
  endsequence
  sequence s_bus_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  AST_BUS_ACK: assert property (
    s_bus_take |=> s_bus_ack)
    else $error("Bus acknowledge not a single cycle after one wait");
  AST_BUS_IDLE: assert property (
    !bus_req |=> avs_waitrequest)
    else $error("Waitrequest low without a request");
  // Write lands only at the edge that sees waitrequest low
  AST_WRITE_LANDS: assert property (
    (avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == REG_CTRL)
      |=> r.loop == $past(avs_writedata[CTRL_LOOP])
      && vco_mult_20 == $past(avs_writedata[CTRL_HALF]))
    else $error("Control write did not land at the acknowledge edge");
  AST_WRITE_MASKED: assert property (
    (avs_write && !avs_waitrequest && !avs_byteenable[0]) |=> vco_mult_20 == $past(vco_mult_20))
    else $error("Masked write still changed control");
  AST_UNMAPPED_READ: assert property (
    (avs_read && avs_waitrequest && avs_address == 4'hc) |=> avs_readdata == 32'h0)
    else $error("Unmapped read returned nonzero data");
  AST_STATUS_READ: assert property (
    (avs_read && avs_waitrequest && avs_address == REG_STATUS)
      |=> avs_readdata[STAT_EN +: 2] == $past(chan_en))
    else $error("Status read does not show latched enables");
  // Per-channel gating of the indicator; amplitude monitor off in loopback
  AST_DISABLED_FAULT_B: assert property (
    !chan_en[1] |=> !link_fault_indicator_n[1])
    else $error("Disabled channel B shows valid signal");
  AST_AMP_FAULT_B: assert property (
    (!r.loop && !amp_ok[1]) |=> !link_fault_indicator_n[1])
    else $error("Low amplitude on channel B did not reach indicator");
  AST_DENS_FAULT_A: assert property (
    dens_fault[0] |=> !link_fault_indicator_n[0])
    else $error("Density fault on channel A did not reach indicator");
  AST_OOR_FAULT: assert property (
    r.oor_s2[0] |=> !link_fault_indicator_n[0])
    else $error("Out-of-range VCO did not reach indicator");
  AST_LOOP_AMP_OFF: assert property (
    r.loop |=> !amp_monitor_enable)
    else $error("Amplitude monitor left on in loopback");
  // Relock ends at the next tick unless the VCO is still out of range
  AST_RELOCK_EXIT: assert property (
    (r.rc[0] == LFSD_RC_RELOCK && r.tick && !r.oor_s2[0]) |=> r.rc[0] == LFSD_RC_TRACK)
    else $error("Relock did not return to tracking");
  AST_TICK_INTERVAL: assert property (
    r.tick |-> $past(r.tick_cnt) == RC_LAST)
    else $error("Sampling tick not at end of interval");
endmodule
`default_nettype wire

// file: tb/lfsd_far.sv
// Far-side model: remote serial transmitter plus amplitude front end.
// Assumes controls change just after a rising edge of sys_clk.
`default_nettype none
module lfsd_far (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Controls from the bench
  input wire logic [1:0] run,
  input wire logic [1:0] amp1,
  input wire logic [1:0] amp2,
  // Pins towards the block
  output logic [1:0] ch0_port1_amp,
  output logic [1:0] ch0_port2_amp,
  output logic [1:0] ch1_port1_amp,
  output logic [1:0] ch1_port2_amp,
  output logic [1:0] line1_bit,
  output logic [1:0] line2_bit,
  output logic [1:0] loop_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] pat0_reg;
  logic [9:0] pat1_reg;
  // Comma-like word: runs of five at most, transitions in every character
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pat0_reg <= 10'h0fa;
      pat1_reg <= 10'h0fa;
    end else begin
      // A stopped line sits at its last level, as a dead transmitter does
      if (run[0]) pat0_reg <= {pat0_reg[8:0], pat0_reg[9]};
      if (run[1]) pat1_reg <= {pat1_reg[8:0], pat1_reg[9]};
    end
  end
  assign line1_bit = {pat1_reg[9], pat0_reg[9]};
  assign line2_bit = line1_bit;
  assign loop_bit = line1_bit;
  assign ch0_port1_amp = amp1;
  assign ch1_port1_amp = amp1;
  assign ch0_port2_amp = amp2;
  assign ch1_port2_amp = amp2;
endmodule
`default_nettype wire

// file: tb/lfsd_top_tb.sv
// Self-checking bench for lfsd_top with a short range control interval.
// Assumes the far-side model lfsd_far and the package lfsd_pkg.
`default_nettype none
module lfsd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lfsd_pkg::*;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [1:0] a1;
    logic [1:0] a2;
    logic [1:0] lfi;
  } lfsd_row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] p0a1, p0a2, p1a1, p1a2, l1, l2, lb;
  logic [1:0] vco_out_of_range = 2'h0;
  logic [1:0] run = 2'h0;
  logic [1:0] amp1 = 2'h0;
  logic [1:0] amp2 = 2'h0;
  logic [1:0] lfi_n, force_ref, chan_en, port_sel, thr;
  logic mult_20, amp_en;
  logic [31:0] q;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  lfsd_row_t rows [10] = '{
    '{8'h00, 2'h1, 2'h0, 2'h3}, '{8'h00, 2'h0, 2'h3, 2'h0},
    '{8'h02, 2'h1, 2'h0, 2'h0}, '{8'h02, 2'h2, 2'h0, 2'h3},
    '{8'h04, 2'h2, 2'h0, 2'h0}, '{8'h04, 2'h3, 2'h0, 2'h3},
    '{8'h30, 2'h3, 2'h0, 2'h0}, '{8'h30, 2'h0, 2'h1, 2'h3},
    '{8'h10, 2'h0, 2'h1, 2'h1}, '{8'h31, 2'h0, 2'h0, 2'h3}};
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  lfsd_far lfsd_far_inst (.sys_clk(sys_clk), .rst(rst), .run(run), .amp1(amp1),
    .amp2(amp2), .ch0_port1_amp(p0a1), .ch0_port2_amp(p0a2), .ch1_port1_amp(p1a1),
    .ch1_port2_amp(p1a2), .line1_bit(l1), .line2_bit(l2), .loop_bit(lb));
  lfsd_top #(.RANGE_PERIODS_P(50)) lfsd_top_inst (.sys_clk(sys_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ch0_port1_amp(p0a1), .ch0_port2_amp(p0a2), .ch1_port1_amp(p1a1),
    .ch1_port2_amp(p1a2), .line1_bit(l1), .line2_bit(l2), .loop_bit(lb),
    .vco_out_of_range(vco_out_of_range), .link_fault_indicator_n(lfi_n),
    .vco_force_ref(force_ref), .vco_mult_20(mult_20), .rx_chan_enable(chan_en),
    .input_port_select(port_sel), .amp_monitor_enable(amp_en),
    .amplitude_threshold_select(thr));
  task automatic summarize();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rd);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic cycles(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  // Bounded wait for one indicator bit to reach a level
  task automatic wait_lfi(input int ch, input logic v, output int cnt);
    cnt = 0;
    while (lfi_n[ch] !== v && cnt < 300) begin
      @(posedge sys_clk);
      cnt++;
    end
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    cycles(12);
    chk({lfi_n, force_ref, chan_en, port_sel, amp_en, mult_20, avs_waitrequest},
        {10'h000, 3'h5});
    rst <= 1'b0;
    run <= 2'h3;
    amp1 <= 2'h1;
    bus(1'b1, REG_ENABLE, 32'h15, 4'h1, q);
    cycles(60);
    foreach (rows[i]) begin
      bus(1'b1, REG_CTRL, {24'h0, rows[i].ctrl}, 4'h1, q);
      amp1 <= rows[i].a1;
      amp2 <= rows[i].a2;
      cycles(8);
      chk(lfi_n, rows[i].lfi);
      chk({port_sel, thr, amp_en},
          {rows[i].ctrl[5:4], rows[i].ctrl[2:1], !rows[i].ctrl[0]});
    end
    bus(1'b1, REG_CTRL, 32'h0, 4'h1, q);
    amp1 <= 2'h1;
    cycles(8);
    // Stuck line on channel A only
    run[0] <= 1'b0;
    wait_lfi(0, 1'b0, n);
    chk(n >= 52 && n <= 68, 1'b1);
    chk(lfi_n[1], 1'b1);
    run[0] <= 1'b1;
    cycles(15);
    chk(lfi_n[0], 1'b0);
    wait_lfi(0, 1'b1, n);
    chk(n <= 25, 1'b1);
    // Range control: force lasts FORCE_PERIODS with the indicator low
    vco_out_of_range[0] <= 1'b1;
    n = 0;
    while (force_ref[0] !== 1'b1 && n < 60) begin
      @(posedge sys_clk);
      n++;
    end
    chk(n < 60, 1'b1);
    vco_out_of_range[0] <= 1'b0;
    n = 0;
    while (force_ref[0] === 1'b1 && n < 20) begin
      chk(lfi_n[0], 1'b0);
      @(posedge sys_clk);
      n++;
    end
    chk(n, FORCE_PERIODS);
    wait_lfi(0, 1'b1, n);
    chk(n <= 60, 1'b1);
    chk(force_ref, 2'h0);
    // Enable latch: hold while strobe low, only bits 0 and 2 count
    bus(1'b1, REG_ENABLE, 32'h01, 4'h1, q);
    chk(chan_en, 2'h3);
    bus(1'b1, REG_ENABLE, 32'h11, 4'h1, q);
    cycles(6);
    chk({chan_en, lfi_n[1]}, 3'h2);
    bus(1'b0, REG_STATUS, 32'h0, 4'hf, q);
    chk(q[7:6], 2'h1);
    bus(1'b1, REG_ENABLE, 32'h1a, 4'h1, q);
    cycles(2);
    chk(chan_en, 2'h0);
    bus(1'b1, REG_ENABLE, 32'h15, 4'h1, q);
    // Refused accesses, then the half-rate reference
    bus(1'b0, 4'hc, 32'h0, 4'hf, q);
    chk(q, 32'h0);
    bus(1'b1, REG_CTRL, 32'h08, 4'h0, q);
    cycles(2);
    chk(mult_20, 1'b0);
    bus(1'b1, REG_CTRL, 32'h08, 4'h1, q);
    cycles(2);
    chk(mult_20, 1'b1);
    cycles(40);
    chk(lfi_n, 2'h3);
    // Mid-run reset: outputs back to idle, channels come back disabled
    rst <= 1'b1;
    cycles(3);
    chk({lfi_n, force_ref, chan_en, port_sel, amp_en, mult_20, avs_waitrequest},
        {10'h000, 3'h5});
    rst <= 1'b0;
    cycles(2);
    chk({chan_en, lfi_n}, 4'h0);
    summarize();
  end
endmodule
`default_nettype wire
